// ---- sim/lcrcmd_assertions.sv ----
/*
  Port-level properties of the trigger, fetch and correction block.
  Assumes it is bound onto lcrcmd_top: one clock, synchronous reset.
*/
module lcrcmd_checker
  import lcrcmd_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire lcr_bus_t    i_bus,
  input wire logic [31:0] o_rdata,
  input wire logic        o_meas_start,
  input wire lcr_corr_t   o_corr,
  input wire lcr_cfg_t    o_cfg
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  wire w_src = i_bus.wr && i_bus.addr == 8'h00;
  wire w_trg = i_bus.wr && i_bus.addr == 8'h04;
  wire w_dly = i_bus.wr && i_bus.addr == 8'h08;
  wire w_len = i_bus.wr && i_bus.addr == 8'h0C;
  wire w_en0 = i_bus.wr && i_bus.addr == 8'h14;

  chk_reset_src:
    assert property ($past(i_rst) |-> o_cfg.src == SRC_INT)
    else $error("source not internal after reset");
  chk_src_write:
    assert property (w_src |=> o_cfg.src == $past(i_bus.wdata[1:0]))
    else $error("source write not taken");
  chk_delay_min:
    assert property (w_dly && i_bus.wdata[31] |=> o_cfg.delay_ms == 16'h0000)
    else $error("minimum delay not zero");
  chk_delay_max:
    assert property (w_dly && i_bus.wdata[31:30] == 2'b01
                     |=> o_cfg.delay_ms == 16'hEA60)
    else $error("maximum delay not sixty seconds");
  chk_delay_range:
    assert property (o_cfg.delay_ms <= 16'hEA60)
    else $error("delay above sixty seconds");
  chk_len_write:
    assert property (w_len |=> o_cfg.len == (($past(i_bus.wdata) <= 32'h2)
                     ? $past(i_bus.wdata[1:0]) : $past(o_cfg.len)))
    else $error("cable length wrong");
  chk_open_enable:
    assert property (w_en0 && i_bus.wdata[31:1] == 31'h0000_0018
                     |=> o_cfg.en[0] == $past(i_bus.wdata[0]))
    else $error("open enable wrong");
  chk_load_range:
    assert property (o_cfg.load_type < 5'h14)
    else $error("load type out of range");
  chk_bus_refused:
    assert property (w_trg && i_bus.wdata[0] && o_cfg.src inside
                     {SRC_EXT, SRC_HOLD} |=> !o_meas_start [*3])
    else $error("bus shot acted under other source");
  chk_start_pulse:
    assert property (o_meas_start |=> !o_meas_start)
    else $error("start longer than one cycle");
  chk_sweep_start:
    assert property ($rose(o_corr.active) |-> o_corr.point == 6'h00)
    else $error("sweep not from point zero");
  chk_point_max:
    assert property (o_corr.active |-> o_corr.point <= 6'h28)
    else $error("sweep point above last");
  chk_rdata_idle:
    assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside read slot");

  cover property (o_meas_start);
  cover property ($fell(o_corr.active));
  cover property (w_trg && o_cfg.src == SRC_BUS);
endmodule

// ---- sim/lcrcmd_meas_model.sv ----
/*
  Measurement engine model on the far side of the command block.
  Assumes one start pulse per measurement; answers after LAT cycles.
*/
module lcrcmd_meas_model
  import lcrcmd_pkg::*;
#(
  parameter int LAT = 6
) (
  input  wire logic     i_clk,
  input  wire logic     i_rst,
  input  wire logic     i_start,
  input  wire lcr_res_t i_set,
  output logic          o_done,
  output lcr_res_t      o_res
);
  timeunit 1ns;
  timeprecision 100ps;
  logic     busy_q;
  logic [7:0] cnt_q;
  // result held only with done; inverted value otherwise
  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    o_res  <= ~i_set;
    if (i_rst) begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
    end else if (i_start) begin
      busy_q <= 1'b1;
      cnt_q  <= 8'h00;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == 8'(LAT - 1)) begin
        busy_q <= 1'b0;
        o_done <= 1'b1;
        o_res  <= i_set;
      end
    end
  end
endmodule

// ---- sim/tb_lcrcmd_top.sv ----
/*
  Self-checking bench of the command block with a measurement model.
  Assumes the constants header is on the include path.
*/
`include "lcrcmd_defines.svh"
module tb_lcrcmd_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lcrcmd_pkg::*;
  logic        i_clk = 0, i_rst = 1, hdl = 0, key = 0, comp = 0, lst = 0;
  lcr_bus_t    bus = '0;
  logic [31:0] rdata;
  logic        start, store, done;
  lcr_corr_t   corr;
  lcr_cfg_t    cfg;
  lcr_res_t    res, set = '0;
  int          n_fail = 0, checks_done = 0, n_start = 0, n_store = 0;
  int          cyc = 0, n0, t0;
  localparam lcr_num_t NA = '{1'b0, 24'h12_3456, 1'b1, 8'h03};
  localparam lcr_num_t NB = '{1'b1, 24'h40_0000, 1'b0, 8'h01};
  localparam string    SA = "+1.23456E-03,-4.00000E+01,";

  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    n_start <= n_start + int'(start);
    n_store <= n_store + int'(store);
  end

  lcrcmd_top #(.P_MS_CYCLES(4)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
    .i_handler_trigger_command(hdl), .i_key_trigger_command(key), .i_res_valid(done),
    .i_res(res), .i_comp_on(comp), .i_list_cmp_on(lst),
    .i_meas_done(done), .o_meas_start(start), .o_corr_store(store),
    .o_corr(corr), .o_cfg(cfg));
  lcrcmd_meas_model u_meas (
    .i_clk(i_clk), .i_rst(i_rst), .i_start(start), .i_set(set),
    .o_done(done), .o_res(res));

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk) bus.wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    @(posedge i_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_clk) bus.rd <= 1'b0;
    #1 check(nm, rdata, e);
  endtask
  task automatic wait_hi(ref logic s, input string nm);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge i_clk) #1;
      if (s === 1'b1) break;
    end
    check(nm, 32'(i < 300), 32'h1);
  endtask
  task automatic shoot(input int lo, hi);
    #1 t0 = cyc;
    wr(`LC_A_TRIGGER_COMMAND, 32'h1);
    wait_hi(start, "start");
    check("start latency", 32'(cyc - t0 >= lo && cyc - t0 <= hi), 32'h1);
    wait_hi(done, "done");
  endtask
  task automatic fetch_cmp(input string e);
    wr(`LC_A_FETCH, 32'h0);
    repeat (45) @(posedge i_clk);
    for (int i = 0; i < e.len(); i++)
      rchk("fetch char", `LC_A_FETCH, 32'(e[i]));
    rchk("fetch end", `LC_A_FETCH, 32'h0);
  endtask
  task automatic res_case(input logic [2:0] st, input logic [3:0] bn,
    input logic [1:0] jd, input lcr_mode_t m, input logic [2:0] sq,
    input logic c, l, input string e);
    set <= '{NA, NB, st, bn, jd, m, sq, 1'b1};
    comp <= c;
    lst <= l;
    // bus source, single shot, then fetch
    shoot(3, 3);
    fetch_cmp(e);
  endtask

  task t_reset;
    rchk("source", `LC_A_TRIGGER_COMMAND_SRC, 32'h0);
    wait_hi(start, "self start");
    rchk("delay", `LC_A_DELAY, 32'h0);
    rchk("length", `LC_A_LEN, 32'h0);
    rchk("channel_select_a", `LC_A_CHANNEL_SELECT_A, 32'h0);
    rchk("load type", `LC_A_LOAD_TYPE, 32'h0);
  endtask
  task t_source;
    for (int s = 0; s < 4; s++) begin
      wr(`LC_A_TRIGGER_COMMAND_SRC, 32'(s));
      rchk("source rb", `LC_A_TRIGGER_COMMAND_SRC, 32'(s));
    end
    repeat (20) @(posedge i_clk);
    n0 = n_start;
    wr(`LC_A_TRIGGER_COMMAND, 32'h1);
    repeat (10) @(posedge i_clk);
    check("hold ignores bus", n_start, n0);
    key <= 1'b1;
    wait_hi(start, "key start");
    key <= 1'b0;
    wait_hi(done, "done");
    wr(`LC_A_TRIGGER_COMMAND_SRC, 32'h1);
    hdl <= 1'b1;
    wait_hi(start, "handler start");
    hdl <= 1'b0;
    wait_hi(done, "done");
    wr(`LC_A_TRIGGER_COMMAND_SRC, 32'h2);
    n0 = n_start;
    wr(`LC_A_TRIGGER_COMMAND, 32'h1);
    wr(`LC_A_TRIGGER_COMMAND, 32'h1);
    repeat (20) @(posedge i_clk);
    check("one shot one start", n_start, n0 + 1);
  endtask
  task t_delay;
    wr(`LC_A_DELAY, 32'h8000_0005);
    rchk("min delay", `LC_A_DELAY, 32'h0);
    shoot(3, 3);
    wr(`LC_A_DELAY, 32'h4000_0000);
    rchk("max delay", `LC_A_DELAY, 32'h0000_EA60);
    wr(`LC_A_DELAY, 32'h0000_EA61);
    rchk("over max", `LC_A_DELAY, 32'h0000_EA60);
    wr(`LC_A_DELAY, 32'h3);
    rchk("delay rb", `LC_A_DELAY, 32'h3);
    shoot(15, 15);
    wr(`LC_A_DELAY, 32'h0);
  endtask
  task t_corr;
    for (int v = 0; v < 4; v++) begin
      wr(`LC_A_LEN, 32'(v));
      rchk("length rb", `LC_A_LEN, 32'(v > 2 ? 2 : v));
    end
    wr(`LC_A_CHANNEL_SELECT_A, 32'h1);
    rchk("channel_select_a rb", `LC_A_CHANNEL_SELECT_A, 32'h1);
    for (int k = 0; k < 6; k++) begin
      wr(8'(`LC_A_EN0 + 4 * k), 32'h31);
      wr(8'(`LC_A_EN0 + 4 * k), 32'h32);
      rchk("enable on", 8'(`LC_A_EN0 + 4 * k), 32'h31);
      wr(8'(`LC_A_EN0 + 4 * k), 32'h30);
      rchk("enable off", 8'(`LC_A_EN0 + 4 * k), 32'h30);
    end
    wr(`LC_A_LOAD_TYPE, 32'h13);
    wr(`LC_A_LOAD_TYPE, 32'h14);
    rchk("load type rb", `LC_A_LOAD_TYPE, 32'h13);
    for (int m = 1; m < 3; m++) begin
      n0 = n_store;
      wr(`LC_A_CORR_RUN, 32'(m));
      for (int i = 0; i < 1000; i++) begin
        @(posedge i_clk) #1;
        if (corr.active !== 1'b1) break;
      end
      // last store pulse is counted one edge after active drops
      @(posedge i_clk) #1;
      check("sweep points", n_store - n0, 32'd41);
      check("sweep kind", corr.short_run, 32'(m == 2));
    end
  endtask
  task t_fetch;
    res_case(3'd0, 4'd10, 2'd0, MODE_NORM, 3'd0, 1, 0,
             {SA, "+0,+10\n"});
    res_case(3'd0, 4'd10, 2'd0, MODE_NORM, 3'd0, 0, 0,
             {SA, "+0\n"});
    res_case(3'd2, 4'd1, 2'd0, MODE_NORM, 3'd0, 0, 0,
             "+9.90000E+37,+9.90000E+37,+2\n");
    res_case(3'd4, 4'd9, 2'd0, MODE_NORM, 3'd0, 1, 0,
             {SA, "+4,+9\n"});
    res_case(3'd0, 4'd0, 2'b11, MODE_LIST, 3'd0, 0, 1,
             {SA, "+0,-1\n"});
    res_case(3'd0, 4'd0, 2'b11, MODE_LIST, 3'd0, 0, 0,
             {SA, "+0,+0\n"});
    res_case(3'd0, 4'd0, 2'b01, MODE_XFMR, 3'd1, 0, 0,
             "+1,+1.23456E-03,-,+1\n");
    res_case(3'd0, 4'd0, 2'b11, MODE_XFMR, 3'd4, 0, 0,
             "+4,+1.23456E-03,-1\n");
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    fetch_cmp("+9.90000E+37,+9.90000E+37,-1\n");
    t_reset;
    t_source;
    t_delay;
    t_corr;
    t_fetch;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    end_of_test;
  end
endmodule

bind lcrcmd_top lcrcmd_checker u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
  .o_meas_start(o_meas_start), .o_corr(o_corr), .o_cfg(o_cfg));

// ---- verilog/lcrcmd_defines.svh ----
/*
  Register offsets, field values and timing constants of the trigger,
  fetch-format and fixture-correction command block.
  Assumes a byte-addressed plain register port with 8-bit addresses.
*/
`ifndef LCRCMD_DEFINES_SVH
`define LCRCMD_DEFINES_SVH

`define LC_A_TRIGGER_COMMAND_SRC  8'h00
`define LC_A_TRIGGER_COMMAND      8'h04
`define LC_A_DELAY     8'h08
`define LC_A_LEN       8'h0C
`define LC_A_CHANNEL_SELECT_A    8'h10
`define LC_A_EN0       8'h14
`define LC_A_LOAD_TYPE 8'h2C
`define LC_A_CORR_RUN  8'h30
`define LC_A_STATUS    8'h34
`define LC_A_FETCH     8'h38

`define LC_EN_COUNT    3'h6
`define LC_DELAY_MIN_B 31
`define LC_DELAY_MAX_B 30
`define LC_DELAY_MAX   16'hEA60
`define LC_LEN_MAX     2'h2
`define LC_LOAD_TYPES  5'h14
`define LC_CORR_LAST   6'h28
`define LC_ASCII_ON    8'h31
`define LC_ASCII_OFF   8'h30
`define LC_BUF_DEPTH   40

`define LC_STEP_NS     32'h000F_4240
`define LC_CLK_NS      32'h0000_0004

`endif

// ---- verilog/lcrcmd_pkg.sv ----
/*
  Types of the trigger, fetch-format and correction command block.
  Assumes the constants header is compiled alongside.
*/
package lcrcmd_pkg;

  typedef enum logic [1:0] {
    SRC_INT  = 2'b00,
    SRC_EXT  = 2'b01,
    SRC_BUS  = 2'b10,
    SRC_HOLD = 2'b11
  } lcr_src_t;

  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_WAIT = 2'b01,
    TS_MEAS = 2'b10
  } lcr_ts_t;

  typedef enum logic [1:0] {
    MODE_NORM = 2'b00,
    MODE_LIST = 2'b01,
    MODE_XFMR = 2'b10
  } lcr_mode_t;

  typedef enum logic [2:0] {
    F_IDLE = 3'b000,
    F_SEQ  = 3'b001,
    F_A    = 3'b010,
    F_B    = 3'b011,
    F_ST   = 3'b100,
    F_BIN  = 3'b101,
    F_JDG  = 3'b110
  } lcr_fld_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lcr_bus_t;

  typedef struct packed {
    logic        sgn;
    logic [23:0] mant;
    logic        esgn;
    logic [7:0]  exp;
  } lcr_num_t;

  typedef struct packed {
    lcr_num_t    a;
    lcr_num_t    b;
    logic [2:0]  state;
    logic [3:0]  bin;
    logic [1:0]  judge;
    lcr_mode_t   mode;
    logic [2:0]  seq;
    logic        phase_rev;
  } lcr_res_t;

  typedef struct packed {
    logic        active;
    logic        short_run;
    logic [5:0]  point;
  } lcr_corr_t;

  typedef struct packed {
    lcr_src_t    src;
    logic [15:0] delay_ms;
    logic [1:0]  len;
    logic        multi;
    logic [4:0]  load_type;
    logic [5:0]  en;
  } lcr_cfg_t;

endpackage

// ---- verilog/lcrcmd_top.sv ----
/*
  Trigger control, fetch result formatting and fixture correction
  settings of a precision impedance meter, reached over a plain
  register port.
  Assumes one 250 MHz clock, handler and key pins asynchronous,
  results and measurement-done from logic on the same clock.
*/
// The implementer's own choices: the plain strobed port and the register offsets.
`include "lcrcmd_defines.svh"
// Notes on behaviour
// R1 - one single-shot trigger starts exactly one measurement
// R2 - trigger source: internal, handler port, bus command, front key
// R3 - reset selects internal self-running triggering
// R4 - post-trigger delay 0 to 60 s in 1 ms steps
// R5 - minimum keyword sets the delay to zero
// R6 - maximum keyword sets the delay to sixty seconds
// R7 - primary and secondary results are 12-character exponent fields
// R8 - state codes -1 empty, 0 normal, 1 to 4 fault kinds
// R9 - state field is sign plus one digit
// R10 - states -1, 1, 2 report 9.9E37 in data fields
// R11 - bin field 0 out of limits, 1 to 9 bins, 10 auxiliary
// R12 - bin field appended only while comparator is on
// R13 - bin field is sign plus one or two digits
// R14 - list judgment -1 low, 0 good, 1 high, two characters
// R15 - list judgment reads 0 while list comparison is off
// R16 - transformer result opens with item sequence number 1 to 4
// R17 - turns ratio secondary field is the phase sign
// R18 - sequence above 3 drops the secondary field
// R19 - cable length accepts only 0, 1 or 2 metres
// R20 - correction channel_select_a single or multi channel, readable
// R21 - open and short correction sweep 41 preset points
// R22 - enables take ASCII '1' as on and '0' as off
// R23 - load correction holds one of twenty parameter pairs, readable
// R24 - each spot frequency point has its own readable enable
// R25 - bus single-shot trigger acts only under bus source
// R26 - host selects bus source, triggers, then fetches
module lcrcmd_top
  import lcrcmd_pkg::*;
#(
  parameter int unsigned P_MS_CYCLES = `LC_STEP_NS / `LC_CLK_NS
) (
  input  wire logic     i_clk,
  input  wire logic     i_rst,
  input  wire lcr_bus_t i_bus,
  output logic [31:0]   o_rdata,
  input  wire logic     i_handler_trigger_command,
  input  wire logic     i_key_trigger_command,
  input  wire logic     i_res_valid,
  input  wire lcr_res_t i_res,
  input  wire logic     i_comp_on,
  input  wire logic     i_list_cmp_on,
  input  wire logic     i_meas_done,
  output logic          o_meas_start,
  output logic          o_corr_store,
  output lcr_corr_t     o_corr,
  output lcr_cfg_t      o_cfg
);

  function automatic logic [7:0] dig(input logic [3:0] d);
    return {4'h3, d};
  endfunction

  function automatic logic [7:0] sgn(input logic neg);
    return neg ? 8'h2D : 8'h2B;
  endfunction

  function automatic logic [7:0] num_ch(input lcr_num_t n,
                                        input logic [3:0] i);
    logic [7:0] c;
    unique case (i)
      4'h0:    c = sgn(n.sgn);
      4'h1:    c = dig(n.mant[23:20]);
      4'h2:    c = 8'h2E;
      4'h3:    c = dig(n.mant[19:16]);
      4'h4:    c = dig(n.mant[15:12]);
      4'h5:    c = dig(n.mant[11:8]);
      4'h6:    c = dig(n.mant[7:4]);
      4'h7:    c = dig(n.mant[3:0]);
      4'h8:    c = 8'h45;
      4'h9:    c = sgn(n.esgn);
      4'hA:    c = dig(n.exp[7:4]);
      default: c = dig(n.exp[3:0]);
    endcase
    return c;
  endfunction

  // register port decode
  logic wr_src, wr_trigger_command, wr_dly, wr_len, wr_meth, wr_type;
  logic wr_run, wr_fetch, rd_fetch;
  logic [31:0] wd;
  assign wd       = i_bus.wdata;
  assign wr_src   = i_bus.wr && i_bus.addr == `LC_A_TRIGGER_COMMAND_SRC;
  assign wr_trigger_command  = i_bus.wr && i_bus.addr == `LC_A_TRIGGER_COMMAND;
  assign wr_dly   = i_bus.wr && i_bus.addr == `LC_A_DELAY;
  assign wr_len   = i_bus.wr && i_bus.addr == `LC_A_LEN;
  assign wr_meth  = i_bus.wr && i_bus.addr == `LC_A_CHANNEL_SELECT_A;
  assign wr_type  = i_bus.wr && i_bus.addr == `LC_A_LOAD_TYPE;
  assign wr_run   = i_bus.wr && i_bus.addr == `LC_A_CORR_RUN;
  assign wr_fetch = i_bus.wr && i_bus.addr == `LC_A_FETCH;
  assign rd_fetch = i_bus.rd && i_bus.addr == `LC_A_FETCH;

  // configuration registers
  lcr_src_t    src_q;
  logic [15:0] dly_q;
  logic [1:0]  len_q;
  logic        multi_q;
  logic [4:0]  type_q;
  logic [5:0]  en_q;
  logic [5:0]  en_rhit;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // R3 internal after reset
      src_q   <= SRC_INT;
      dly_q   <= 16'h0000;
      len_q   <= 2'h0;
      multi_q <= 1'b0;
      type_q  <= 5'h00;
    end else begin
      // R2 four sources
      if (wr_src) begin
        src_q <= lcr_src_t'(wd[1:0]);
      end
      // R5 minimum keyword
      if (wr_dly && wd[`LC_DELAY_MIN_B]) begin
        dly_q <= 16'h0000;
      // R6 maximum keyword
      end else if (wr_dly && wd[`LC_DELAY_MAX_B]) begin
        dly_q <= `LC_DELAY_MAX;
      // R4 range check
      end else if (wr_dly && wd[15:0] <= `LC_DELAY_MAX) begin
        dly_q <= wd[15:0];
      end
      // R19 only 0..2 m
      if (wr_len && wd[31:2] == 30'h0 && wd[1:0] <= `LC_LEN_MAX) begin
        len_q <= wd[1:0];
      end
      // R20 channel_select_a select
      if (wr_meth) begin
        multi_q <= wd[0];
      end
      // R23 twenty pair types
      if (wr_type && wd[31:5] == 27'h0 && wd[4:0] < `LC_LOAD_TYPES) begin
        type_q <= wd[4:0];
      end
    end
  end

  // open, short, load, then the three spot points
  for (genvar i = 0; i < 6; i++) begin : g_en
    logic hit;
    assign hit        = i_bus.addr == 8'(`LC_A_EN0 + 4 * i);
    assign en_rhit[i] = hit;
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        en_q[i] <= 1'b0;
      // R22 ascii on/off
      end else if (i_bus.wr && hit && wd[31:8] == 24'h0) begin
        // R24 spot enables
        if (wd[7:0] == `LC_ASCII_ON) begin
          en_q[i] <= 1'b1;
        end else if (wd[7:0] == `LC_ASCII_OFF) begin
          en_q[i] <= 1'b0;
        end
      end
    end
  end

  // pin synchronisers, stage one read only by stage two
  logic [1:0] sy1_q, sy2_q, sy3_q;
  logic       hdl_edge, key_edge;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sy1_q <= 2'h0;
      sy2_q <= 2'h0;
      sy3_q <= 2'h0;
    end else begin
      sy1_q <= {i_key_trigger_command, i_handler_trigger_command};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end
  assign hdl_edge = sy2_q[0] && !sy3_q[0];
  assign key_edge = sy2_q[1] && !sy3_q[1];

  // trigger sequencer
  lcr_ts_t     ts_q;
  logic [17:0] div_q;
  logic [15:0] ms_q;
  logic        tick, trigger_command_ev, start_q, store_q;
  logic        cact_q, cshort_q;
  logic [5:0]  cpt_q;

  assign tick = div_q == 18'(P_MS_CYCLES - 1);
  // R25 bus trigger gated
  assign trigger_command_ev = (src_q == SRC_INT)
                || (src_q == SRC_EXT && hdl_edge)
                || (src_q == SRC_BUS && wr_trigger_command && wd[0])
                || (src_q == SRC_HOLD && key_edge);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ts_q     <= TS_IDLE;
      div_q    <= 18'h0_0000;
      ms_q     <= 16'h0000;
      start_q  <= 1'b0;
      store_q  <= 1'b0;
      cact_q   <= 1'b0;
      cshort_q <= 1'b0;
      cpt_q    <= 6'h00;
    end else begin
      start_q <= 1'b0;
      store_q <= 1'b0;
      unique case (ts_q)
        TS_IDLE: begin
          div_q <= 18'h0_0000;
          ms_q  <= 16'h0000;
          // R21 sweep start
          if (wr_run && (wd[0] || wd[1]) && !cact_q) begin
            cact_q   <= 1'b1;
            cshort_q <= !wd[0];
            cpt_q    <= 6'h00;
          end else if (cact_q) begin
            start_q <= 1'b1;
            ts_q    <= TS_MEAS;
          // R1 one trigger, one cycle
          end else if (trigger_command_ev) begin
            ts_q <= TS_WAIT;
          end
        end
        TS_WAIT: begin
          // R4 ms delay count
          if (ms_q >= dly_q) begin
            start_q <= 1'b1;
            ts_q    <= TS_MEAS;
          end else if (tick) begin
            div_q <= 18'h0_0000;
            ms_q  <= ms_q + 16'h0001;
          end else begin
            div_q <= div_q + 18'h0_0001;
          end
        end
        TS_MEAS: begin
          if (i_meas_done) begin
            ts_q <= TS_IDLE;
            // R21 41 points stored
            if (cact_q) begin
              store_q <= 1'b1;
              if (cpt_q == `LC_CORR_LAST) begin
                cact_q <= 1'b0;
              end else begin
                cpt_q <= cpt_q + 6'h01;
              end
            end
          end
        end
        default: ts_q <= TS_IDLE;
      endcase
    end
  end

  // result latch; a new result beats the fetch consume
  lcr_res_t res_q, snap_d, r_q;
  logic     have_q, comp_q, lcmp_q;
  always_comb begin
    snap_d = res_q;
    // R8 empty buffer state
    if (!have_q) begin
      snap_d       = '0;
      snap_d.state = 3'b111;
    end
  end

  // formatter: one character per cycle into the line buffer
  lcr_fld_t   fld_q, nxt;
  logic [3:0] cnt_q, flen;
  logic [5:0] wptr_q, rptr_q;
  logic [7:0] mem [`LC_BUF_DEPTH];
  logic [7:0] ch, rch_q;
  logic       sep, is_x, bad, st_neg, pha, jneg, jone;
  logic [2:0] st_mag;
  lcr_num_t   num, ovf;

  assign is_x   = r_q.mode == MODE_XFMR;
  // only -1 is negative; +4 shares the top bit with it
  assign st_neg = r_q.state == 3'b111;
  assign st_mag = st_neg ? 3'(-r_q.state) : r_q.state;
  // R10 fault states
  assign bad = r_q.state == 3'b111 || r_q.state == 3'h1
            || r_q.state == 3'h2;
  assign ovf = {1'b0, 24'h99_0000, 1'b0, 8'h37};
  assign num = bad ? ovf : (fld_q == F_B ? r_q.b : r_q.a);
  // R17 phase sign
  assign pha = is_x && r_q.seq == 3'h1;
  // R15 judgment zero when off
  assign jneg = (is_x || lcmp_q) && r_q.judge == 2'b11;
  assign jone = (is_x || lcmp_q) && r_q.judge != 2'b00;

  always_comb begin
    nxt = F_IDLE;
    unique case (fld_q)
      // R16 sequence first
      F_IDLE: nxt = is_x ? F_SEQ : F_A;
      F_SEQ:  nxt = F_A;
      // R18 no secondary above 3
      F_A:    nxt = (is_x && r_q.seq > 3'h3) ? F_JDG
                  : F_B;
      F_B:    nxt = is_x ? F_JDG : F_ST;
      // R12 bin only with comparator
      F_ST:   nxt = r_q.mode == MODE_LIST ? F_JDG
                  : (comp_q ? F_BIN : F_IDLE);
      F_BIN:  nxt = F_IDLE;
      F_JDG:  nxt = F_IDLE;
      default: nxt = F_IDLE;
    endcase
  end

  always_comb begin
    flen = 4'h2;
    unique case (fld_q)
      // R7 twelve characters
      F_A:   flen = 4'hC;
      F_B:   flen = pha ? 4'h1 : 4'hC;
      // R13 two or three characters
      F_BIN: flen = r_q.bin >= 4'hA ? 4'h3 : 4'h2;
      default: flen = 4'h2;
    endcase
  end
  assign sep = cnt_q == flen;

  always_comb begin
    ch = 8'h00;
    if (sep) begin
      ch = nxt == F_IDLE ? 8'h0A : 8'h2C;
    end else begin
      unique case (fld_q)
        F_SEQ: ch = cnt_q == 4'h0 ? 8'h2B : dig({1'b0, r_q.seq});
        F_A:   ch = num_ch(num, cnt_q);
        F_B:   ch = pha ? sgn(r_q.phase_rev) : num_ch(num, cnt_q);
        // R9 sign and digit
        F_ST:  ch = cnt_q == 4'h0 ? sgn(st_neg) : dig({1'b0, st_mag});
        // R11 bin codes
        F_BIN: begin
          if (cnt_q == 4'h0) begin
            ch = 8'h2B;
          end else if (r_q.bin >= 4'hA) begin
            ch = cnt_q == 4'h1 ? 8'h31 : 8'h30;
          end else begin
            ch = dig(r_q.bin);
          end
        end
        // R14 judgment codes
        F_JDG: ch = cnt_q == 4'h0 ? sgn(jneg) : dig({3'h0, jone});
        default: ch = 8'h00;
      endcase
    end
  end

  logic fmt_busy, can_rd;
  assign fmt_busy = fld_q != F_IDLE;
  assign can_rd   = !fmt_busy && rptr_q < wptr_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      res_q  <= '0;
      have_q <= 1'b0;
      r_q    <= '0;
      comp_q <= 1'b0;
      lcmp_q <= 1'b0;
      fld_q  <= F_IDLE;
      cnt_q  <= 4'h0;
      wptr_q <= 6'h00;
      rptr_q <= 6'h00;
    end else begin
      if (wr_fetch && !fmt_busy) begin
        r_q    <= snap_d;
        comp_q <= i_comp_on && have_q;
        lcmp_q <= i_list_cmp_on;
        have_q <= 1'b0;
        fld_q  <= snap_d.mode == MODE_XFMR ? F_SEQ : F_A;
        cnt_q  <= 4'h0;
        wptr_q <= 6'h00;
        rptr_q <= 6'h00;
      end else if (fmt_busy) begin
        wptr_q <= wptr_q + 6'h01;
        cnt_q  <= sep ? 4'h0 : cnt_q + 4'h1;
        if (sep) begin
          fld_q <= nxt;
        end
      end else if (rd_fetch && can_rd) begin
        rptr_q <= rptr_q + 6'h01;
      end
      if (i_res_valid) begin
        res_q  <= i_res;
        have_q <= 1'b1;
      end
    end
  end

  // buffer write port kept free of reset, it is plain storage
  always_ff @(posedge i_clk) begin
    if (fmt_busy) begin
      mem[wptr_q] <= ch;
    end
  end
  assign rch_q = can_rd ? mem[rptr_q] : 8'h00;

  // read data mux
  logic [31:0] rd_mux, rdata_q;
  logic [31:0] st_word;
  assign st_word = {24'h0, cact_q, ts_q, have_q, fmt_busy,
                    can_rd, multi_q, 1'b0};
  assign rd_mux =
      i_bus.addr == `LC_A_TRIGGER_COMMAND_SRC  ? {30'h0, src_q}
    : i_bus.addr == `LC_A_DELAY     ? {16'h0, dly_q}
    : i_bus.addr == `LC_A_LEN       ? {30'h0, len_q}
    : i_bus.addr == `LC_A_CHANNEL_SELECT_A    ? {31'h0, multi_q}
    : i_bus.addr == `LC_A_LOAD_TYPE ? {27'h0, type_q}
    : i_bus.addr == `LC_A_CORR_RUN  ? {26'h0, cpt_q}
    : i_bus.addr == `LC_A_STATUS    ? st_word
    : i_bus.addr == `LC_A_FETCH     ? {24'h0, rch_q}
    : |en_rhit ? {24'h0, 7'h18, |(en_rhit & en_q)}
    : 32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= i_bus.rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign o_rdata      = rdata_q;
  assign o_meas_start = start_q;
  assign o_corr_store = store_q;
  assign o_corr       = '{active: cact_q, short_run: cshort_q,
                          point: cpt_q};
  assign o_cfg        = '{src: src_q, delay_ms: dly_q, len: len_q,
                          multi: multi_q, load_type: type_q,
                          en: en_q};

endmodule
